// *** rtl/alu_status_consts.vh ***
// named constants for the arithmetic status flag register
`ifndef ALU_STATUS_CONSTS_VH
`define ALU_STATUS_CONSTS_VH

// ==========================================================
// data and register widths
`define DATA_W 8
`define FLAG_W 5
`define ADDR_W 2
`define OP_W 4
`define BITSEL_W 3

// ==========================================================
// flag bit positions inside the status register and nibble bit bounds of a data byte
`define NEG_BIT 4
`define OVF_BIT 3
`define ZERO_BIT 2
`define HALF_BIT 1
`define CARRY_BIT 0
`define NIB_HI 7
`define NIB_HI_LO 4
`define NIB_LO_HI 3
`define NIB_LO 0

// ==========================================================
// register map of the software port
`define STAT_ADDR 2'h0
`define RES_ADDR 2'h1
`define LASTOP_ADDR 2'h2

// ==========================================================
// reset values and fill patterns
`define STAT_RST 5'h00
`define RES_RST 8'h00
`define OP_RST 4'h0
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF
`define BYTE_ONE 8'h01
`define UPPER_ZERO 3'h0
`define NIB_ZERO 4'h0
`define FLAGS_NONE 5'h00
`define FLAGS_ALL 5'h1F
`define FLAGS_NZ 5'h14
`define FLAGS_Z 5'h04
`define FLAGS_NOVZ 5'h1C

// ==========================================================
// operation codes driven by the execution datapath
`define OP_ADD 4'h0
`define OP_ADDC 4'h1
`define OP_SUB 4'h2
`define OP_SUBB 4'h3
`define OP_AND 4'h4
`define OP_IOR 4'h5
`define OP_XOR 4'h6
`define OP_CLR 4'h7
`define OP_FILE_TO_FILE_MOVE_INSTRUCTION 4'h8
`define OP_ACCUMULATOR_STORE_INSTRUCTION 4'h9
`define OP_BCLR 4'hA
`define OP_BSET 4'hB
`define OP_SWAP 4'hC
`define OP_INC 4'hD
`define OP_DEC 4'hE
`define OP_COMF 4'hF

`endif

// *** rtl/flag_adder.v ***
// eight-bit adder that also reports half carry, carry and signed overflow
`timescale 1ns/100ps
`include "alu_status_consts.vh"

module flag_adder #(
  parameter W = 8
) (
  // operands
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire cin,
  // results
  output wire [W-1:0] sum,
  output wire half_carry,
  output wire carry,
  output wire ovf
);

  // ==========================================================
  // split add so the carry out of the low nibble is visible
  wire [`NIB_HI_LO:0] lo;
  wire [W-`NIB_HI_LO:0] hi;

  assign lo = {1'b0, a[`NIB_LO_HI:`NIB_LO]} + {1'b0, b[`NIB_LO_HI:`NIB_LO]} + {`NIB_ZERO, cin};
  assign hi = {1'b0, a[W-1:`NIB_HI_LO]} + {1'b0, b[W-1:`NIB_HI_LO]}
    + {{(W-`NIB_HI_LO){1'b0}}, lo[`NIB_HI_LO]};
  assign sum = {hi[W-`NIB_HI_LO-1:0], lo[`NIB_LO_HI:`NIB_LO]};
  // carry out of the fourth low-order bit [RULE9]
  assign half_carry = lo[`NIB_HI_LO];
  // carry out of the most significant bit [RULE9]
  assign carry = hi[W-`NIB_HI_LO];
  // sign changes although both addends share a sign [RULE7]
  assign ovf = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);

endmodule // flag_adder

// *** rtl/alu_status_flag_register.v ***
// status flag register of the core with its flag-producing alu
`timescale 1ns/100ps
`include "alu_status_consts.vh"

// How it works
// RULE1 - status register is an ordinary operand: source or destination of any operation.
// RULE2 - flag-affecting operation aimed at status: flags take alu values, write blocked.
// RULE3 - clear aimed at status sets zero flag only, others kept.
// RULE4 - bit clear, bit set, swap and both moves leave all five flags alone.
// RULE5 - subtraction uses carry and half carry as inverted borrow indicators.
// RULE6 - negative flag at bit 4 copies result msb.
// RULE7 - overflow flag at bit 3 set when signed result changes sign wrongly.
// RULE8 - zero flag at bit 2 set when result is zero.
// RULE9 - half carry bit 1 from low nibble, carry bit 0 from msb.
// RULE10 - upper three status bits unimplemented: read zero, writes ignored.
module alu_status_flag_register (
  // clock and reset
  input wire CLK,
  input wire NRST,
  // software register port
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`DATA_W-1:0] RDATA,
  // execution datapath request
  input wire OP_VALID,
  input wire [`OP_W-1:0] OP_CODE,
  input wire [`DATA_W-1:0] OP_FILE,
  input wire [`DATA_W-1:0] OP_ACC,
  input wire [`BITSEL_W-1:0] OP_BITSEL,
  input wire OP_SRC_STATUS,
  input wire OP_DST_STATUS,
  // execution datapath answer
  output wire [`DATA_W-1:0] RESULT,
  output wire [`DATA_W-1:0] STATUS
);

  // ==========================================================
  // state
  reg [`FLAG_W-1:0] stat_q;
  reg [`FLAG_W-1:0] stat_d;
  reg [`DATA_W-1:0] res_q;
  reg [`OP_W-1:0] lastop_q;
  wire [`DATA_W-1:0] stat_byte;

  // upper bits are unimplemented and always zero [RULE10]
  assign stat_byte = {`UPPER_ZERO, stat_q};
  assign STATUS = stat_byte;
  assign RESULT = res_q;

  // ==========================================================
  // operand selection
  wire [`DATA_W-1:0] opa;
  // status byte may be fetched as the file operand [RULE1]
  assign opa = OP_SRC_STATUS ? stat_byte : OP_FILE;

  // ==========================================================
  // adder steering
  reg [`DATA_W-1:0] add_b;
  reg add_cin;
  wire [`DATA_W-1:0] add_sum;
  wire add_hc;
  wire add_c;
  wire add_ovf;

  always @* begin
    add_b = OP_ACC;
    add_cin = 1'b0;
    case (OP_CODE)
      `OP_ADD: begin
        add_b = OP_ACC;
        add_cin = 1'b0;
      end
      `OP_ADDC: begin
        add_b = OP_ACC;
        add_cin = stat_q[`CARRY_BIT];
      end
      // subtract by adding the two's complement, so carry set means no borrow [RULE5]
      `OP_SUB: begin
        add_b = ~OP_ACC;
        add_cin = 1'b1;
      end
      // borrow in is the inverted carry flag [RULE5]
      `OP_SUBB: begin
        add_b = ~OP_ACC;
        add_cin = stat_q[`CARRY_BIT];
      end
      `OP_INC: begin
        add_b = `BYTE_ZERO;
        add_cin = 1'b1;
      end
      `OP_DEC: begin
        add_b = `BYTE_ONES;
        add_cin = 1'b0;
      end
      default: begin
        add_b = OP_ACC;
        add_cin = 1'b0;
      end
    endcase
  end

  flag_adder #(
    .W(`DATA_W)
  ) u_adder (
    .a(opa),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .half_carry(add_hc),
    .carry(add_c),
    .ovf(add_ovf)
  );

  // ==========================================================
  // result and affected-flag mask per operation
  reg [`DATA_W-1:0] res_d;
  reg [`FLAG_W-1:0] mask;
  wire [`DATA_W-1:0] bit_onehot;

  assign bit_onehot = `BYTE_ONE << OP_BITSEL;

  always @* begin
    res_d = opa;
    mask = `FLAGS_NONE;
    case (OP_CODE)
      `OP_ADD, `OP_ADDC, `OP_SUB, `OP_SUBB: begin
        res_d = add_sum;
        mask = `FLAGS_ALL;
      end
      // inc and dec have no borrow flag of interest beyond the full set
      `OP_INC, `OP_DEC: begin
        res_d = add_sum;
        mask = `FLAGS_ALL;
      end
      `OP_AND: begin
        res_d = opa & OP_ACC;
        mask = `FLAGS_NZ;
      end
      `OP_IOR: begin
        res_d = opa | OP_ACC;
        mask = `FLAGS_NZ;
      end
      `OP_XOR: begin
        res_d = opa ^ OP_ACC;
        mask = `FLAGS_NZ;
      end
      `OP_COMF: begin
        res_d = ~opa;
        mask = `FLAGS_NZ;
      end
      // clear touches only the zero flag [RULE3]
      `OP_CLR: begin
        res_d = `BYTE_ZERO;
        mask = `FLAGS_Z;
      end
      // moves, bit ops and swap change no flag [RULE4]
      `OP_FILE_TO_FILE_MOVE_INSTRUCTION: begin
        res_d = opa;
        mask = `FLAGS_NONE;
      end
      `OP_ACCUMULATOR_STORE_INSTRUCTION: begin
        res_d = OP_ACC;
        mask = `FLAGS_NONE;
      end
      `OP_BCLR: begin
        res_d = opa & ~bit_onehot;
        mask = `FLAGS_NONE;
      end
      `OP_BSET: begin
        res_d = opa | bit_onehot;
        mask = `FLAGS_NONE;
      end
      `OP_SWAP: begin
        res_d = {opa[`NIB_LO_HI:`NIB_LO], opa[`NIB_HI:`NIB_HI_LO]};
        mask = `FLAGS_NONE;
      end
      default: begin
        res_d = opa;
        mask = `FLAGS_NONE;
      end
    endcase
  end

  // ==========================================================
  // flag values produced by the alu
  wire [`FLAG_W-1:0] alu_flags;

  assign alu_flags[`NEG_BIT] = res_d[`DATA_W-1]; // [RULE6]
  assign alu_flags[`OVF_BIT] = add_ovf; // [RULE7]
  assign alu_flags[`ZERO_BIT] = (res_d == `BYTE_ZERO); // [RULE8]
  assign alu_flags[`HALF_BIT] = add_hc; // [RULE9]
  assign alu_flags[`CARRY_BIT] = add_c; // [RULE9]

  // ==========================================================
  // next status value
  // an operation in flight wins over a software write in the same cycle;
  // the datapath owns the register while an instruction retires
  always @* begin
    stat_d = stat_q;
    if (OP_VALID) begin
      if (OP_DST_STATUS && (mask != `FLAGS_NONE)) begin
        // destination write blocked; affected flags from alu, rest kept [RULE2] [RULE3]
        stat_d = (mask & alu_flags) | (~mask & stat_q);
      end else if (OP_DST_STATUS) begin
        // flag-neutral ops store their result like any register [RULE1] [RULE4]
        stat_d = res_d[`FLAG_W-1:0];
      end else begin
        stat_d = (mask & alu_flags) | (~mask & stat_q);
      end
    end else if (WR && (ADDR == `STAT_ADDR)) begin
      // only the five flags are stored; upper bits dropped [RULE1] [RULE10]
      stat_d = WDATA[`FLAG_W-1:0];
    end
  end

  // ==========================================================
  // registers
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stat_q <= `STAT_RST;
      res_q <= `RES_RST;
      lastop_q <= `OP_RST;
    end else begin
      stat_q <= stat_d;
      if (OP_VALID) begin
        res_q <= res_d;
        lastop_q <= OP_CODE;
      end
    end
  end

  // ==========================================================
  // read port: data one cycle after the strobe, zero otherwise
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= `BYTE_ZERO;
    end else if (RD) begin
      case (ADDR)
        `STAT_ADDR: RDATA <= stat_byte; // [RULE10]
        `RES_ADDR: RDATA <= res_q;
        `LASTOP_ADDR: RDATA <= {`NIB_ZERO, lastop_q};
        default: RDATA <= `BYTE_ZERO;
      endcase
    end else begin
      RDATA <= `BYTE_ZERO;
    end
  end

endmodule // alu_status_flag_register

// *** test/alu_status_chk_sva.sv ***
// checker for the status flag register ports
`timescale 1ns/100ps
module alu_status_chk (
  // clock and reset
  input wire CLK,
  input wire NRST,
  // software port
  input wire [1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  // operation port
  input wire OP_VALID,
  input wire [3:0] OP_CODE,
  input wire [7:0] OP_FILE,
  input wire [7:0] OP_ACC,
  input wire OP_SRC_STATUS,
  input wire OP_DST_STATUS,
  input wire [7:0] RESULT,
  input wire [7:0] STATUS
);
  // ====
  // helpers
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // clr excluded: it touches zero only
  wire fl = OP_VALID && (OP_CODE < 4'h7 || OP_CODE > 4'hC);
  wire mv = OP_VALID && OP_CODE > 4'h7 && OP_CODE < 4'hD;
  wire ar = OP_VALID && !OP_SRC_STATUS;
  wire c9 = ({1'b0, OP_FILE} + {1'b0, OP_ACC}) > 9'h0FF;
  wire nb = OP_FILE >= OP_ACC;
  wire [4:0] wlo = WDATA[4:0];
  // ====
  // assertions
  AST_UPPER: assert property (STATUS[7:5] == 3'h0) else $error("upper bits set");
  AST_RD_IDLE: assert property (!RD |=> RDATA == 8'h00) else $error("rdata not idle");
  AST_RD_STAT: assert property (RD && ADDR == 2'h0 |=> RDATA == $past(STATUS))
    else $error("status read wrong");
  AST_WR_STAT: assert property (WR && ADDR == 2'h0 && !OP_VALID |=> STATUS[4:0] == $past(wlo))
    else $error("status write lost");
  AST_CLR: assert property (OP_VALID && OP_CODE == 4'h7 |=> STATUS == ($past(STATUS) | 8'h04))
    else $error("clear flags wrong");
  AST_MOVE: assert property (mv && !OP_DST_STATUS |=> $stable(STATUS))
    else $error("move changed flags");
  AST_ZERO: assert property (fl |=> STATUS[2] == (RESULT == 8'h00)) else $error("zero wrong");
  AST_NEG: assert property (fl |=> STATUS[4] == RESULT[7]) else $error("negative wrong");
  AST_CARRY: assert property (ar && OP_CODE == 4'h0 |=> STATUS[0] == $past(c9))
    else $error("carry wrong");
  AST_BORROW: assert property (ar && OP_CODE == 4'h2 |=> STATUS[0] == $past(nb))
    else $error("borrow wrong");
  // ====
  // covers
  COV_CLR_DST: cover property (OP_VALID && OP_CODE == 4'h7 && OP_DST_STATUS);
  COV_WR_OP: cover property (WR && OP_VALID);
  COV_SUB: cover property (ar && OP_CODE == 4'h2 && !nb);
endmodule // alu_status_chk

// *** test/alu_status_flag_register_tb_top.sv ***
// self-checking bench for the status flag register
`timescale 1ns/100ps
`include "alu_status_consts.vh"
module alu_status_flag_register_tb_top;
  // ====
  // stimulus and bookkeeping
  reg CLK = 1'b0;
  reg NRST = 1'b0;
  reg [1:0] ADDR = 2'h0;
  reg [7:0] WDATA = 8'h00;
  reg WR = 1'b0;
  reg RD = 1'b0;
  reg OP_VALID = 1'b0;
  reg [3:0] OP_CODE = 4'h0;
  reg [7:0] OP_FILE = 8'h00;
  reg [7:0] OP_ACC = 8'h00;
  reg [2:0] OP_BITSEL = 3'h0;
  reg OP_SRC_STATUS = 1'b0;
  reg OP_DST_STATUS = 1'b0;
  wire [7:0] RDATA;
  wire [7:0] RESULT;
  wire [7:0] STATUS;
  integer errors = 0;
  integer cmp_count = 0;
  integer seed = 70;
  integer i;
  reg [31:0] rv;
  reg [4:0] st = 5'h00;
  always #10 CLK = ~CLK;
  alu_status_flag_register alu_status_flag_register_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_FILE(OP_FILE), .OP_ACC(OP_ACC), .OP_BITSEL(OP_BITSEL), .OP_SRC_STATUS(OP_SRC_STATUS),
    .OP_DST_STATUS(OP_DST_STATUS), .RESULT(RESULT), .STATUS(STATUS));
  // ====
  // expected {result, flags}; subtraction adds the complement
  function [12:0] model(input [3:0] c, input [7:0] f, input [7:0] a, input s, input d);
    reg [7:0] x, y, r8;
    reg ci;
    reg [8:0] r;
    reg [4:0] h, m, fl;
    begin
      x = s ? {3'h0, st} : f;
      y = (c == `OP_SUB || c == `OP_SUBB) ? ~a : c == `OP_INC ? 8'h00 : c == `OP_DEC ? 8'hFF : a;
      ci = (c == `OP_ADDC || c == `OP_SUBB) ? st[0] : (c == `OP_SUB || c == `OP_INC);
      r = x + y + ci;
      h = x[3:0] + y[3:0] + ci;
      case (c)
        `OP_AND: r8 = x & a;
        `OP_IOR: r8 = x | a;
        `OP_XOR: r8 = x ^ a;
        `OP_CLR: r8 = 8'h00;
        `OP_FILE_TO_FILE_MOVE_INSTRUCTION: r8 = x;
        `OP_ACCUMULATOR_STORE_INSTRUCTION: r8 = a;
        `OP_BCLR: r8 = x & ~(8'h01 << f[2:0]);
        `OP_BSET: r8 = x | (8'h01 << f[2:0]);
        `OP_SWAP: r8 = {x[3:0], x[7:4]};
        `OP_COMF: r8 = ~x;
        default: r8 = r[7:0];
      endcase
      m = (c < 4'h4 || c == `OP_INC || c == `OP_DEC) ? 5'h1F : (c < 4'h7 || c == `OP_COMF) ? 5'h14
        : c == `OP_CLR ? 5'h04 : 5'h00;
      fl = {r8[7], x[7] == y[7] && r[7] != x[7], r8 == 8'h00, h[4], r[8]};
      model = {r8, (d && m == 5'h00) ? r8[4:0] : (st & ~m) | (fl & m)};
    end
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  // ====
  // bus tasks; w also fires a status write beside the operation
  task op(input [3:0] c, input [7:0] f, input [7:0] a, input s, input d, input w);
    reg [12:0] e;
    begin
      e = model(c, f, a, s, d);
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_CODE <= c;
      OP_FILE <= f;
      OP_ACC <= a;
      OP_BITSEL <= f[2:0];
      OP_SRC_STATUS <= s;
      OP_DST_STATUS <= d;
      WR <= w;
      ADDR <= `STAT_ADDR;
      WDATA <= 8'hFF;
      @(posedge CLK);
      OP_VALID <= 1'b0;
      WR <= 1'b0;
      st = e[4:0];
      #1;
      chk(RESULT, e[12:5]);
      chk(STATUS, {3'h0, st});
    end
  endtask
  task wr(input [1:0] ad, input [7:0] dt);
    begin
      @(posedge CLK);
      ADDR <= ad;
      WDATA <= dt;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      if (ad == `STAT_ADDR) st = dt[4:0];
    end
  endtask
  task rd(input [1:0] ad, input [7:0] ex);
    begin
      @(posedge CLK);
      ADDR <= ad;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, ex);
    end
  endtask
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ====
  // tests
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    #1;
    chk(STATUS, 8'h00);
    wr(`STAT_ADDR, 8'hFF);
    rd(`STAT_ADDR, 8'h1F);
    wr(`STAT_ADDR, 8'h0A);
    op(`OP_CLR, 8'h55, 8'h00, 1'b0, 1'b1, 1'b0);
    chk(STATUS, 8'h0E);
    $display("test clear done");
    for (i = 8; i < 13; i = i + 1) op(i[3:0], 8'hA5, 8'h3C, 1'b1, i[0], 1'b0);
    op(`OP_SUB, 8'h05, 8'h05, 1'b0, 1'b0, 1'b0);
    chk(STATUS, 8'h07);
    op(`OP_SUB, 8'h03, 8'h05, 1'b0, 1'b0, 1'b0);
    chk(STATUS, 8'h10);
    rd(2'h2, {4'h0, `OP_SUB});
    op(`OP_ADD, 8'h7F, 8'h01, 1'b0, 1'b1, 1'b0);
    chk(STATUS, 8'h1A);
    op(`OP_ADD, 8'h11, 8'h22, 1'b0, 1'b0, 1'b1);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h33);
    rd(2'h3, 8'h00);
    $display("test corners done");
    // random mix; source and destination may both be the status register
    for (i = 0; i < 300; i = i + 1) begin
      rv = $random(seed);
      op(rv[3:0], rv[11:4], rv[19:12], rv[20], rv[21], 1'b0);
      if (rv[22]) rd(`STAT_ADDR, {3'h0, st});
    end
    $display("test random done");
    // mid-run reset must bring every output back to zero
    @(posedge CLK);
    NRST <= 1'b0;
    @(posedge CLK);
    #1;
    chk(STATUS, 8'h00);
    chk(RESULT, 8'h00);
    chk(RDATA, 8'h00);
    @(posedge CLK);
    NRST <= 1'b1;
    st = 5'h00;
    rd(`STAT_ADDR, 8'h00);
    rd(2'h1, 8'h00);
    $display("test reset done");
    give_verdict;
  end
  initial begin
    #200000;
    errors = errors + 1;
    give_verdict;
  end
endmodule // alu_status_flag_register_tb_top
bind alu_status_flag_register alu_status_chk chk_inst (.*);
